/* File: hw/quad_adc_parallel_read_port.sv */
/*
 * Converter end of the parallel read port: sequences the selected
 * channels, signals per-channel and sequence completion, stores the
 * results and returns them in order on host reads.
 * Assumes the host keeps strobes synchronous to clk_sys and that the
 * raw sample words arrive on sample_in at the start of a sequence.
 */
// Operation
// RULE1: Busy falls when all selected channels done
// RULE2: Each read returns next stored result
// RULE3: Pulse end-of-channel after each channel conversion
// RULE4: Drive results only when select and read
// RULE5: Data ready same cycle, no wait states; the code drives data the cycle after the strobe
// RULE6: Start may come from host or elsewhere
// RULE7: Polling host waits before reading
// RULE8: Shared conversion clock gives identical timing
// RULE9: Host enables two devices on end-of-channel; the host here ignores eoc_n and drives one device
// RULE10: Result bus, select, read, write, status
// RULE11: Bus released when select or read idle
`timescale 1ns/1ps
`include "quad_port_defs.svh"

module quad_adc_parallel_read_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Sampled inputs and channel choice
  input wire quad_port_pkg::ch_mask_t channel_mask,
  input wire logic [`CH_N*`RES_W-1:0] sample_in,
  // Host pins
  quad_port_if.device port
);
  import quad_port_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } conv_state_t;

  conv_state_t state, next_state; // Sequencer state
  result_t store [`CH_N]; // Held results
  result_t next_store [`CH_N];
  ch_mask_t pending, next_pending; // Channels left to convert
  ch_idx_t conv_ch, next_conv_ch; // Channel under conversion
  ch_idx_t wr_ptr, next_wr_ptr; // Next store slot
  ch_idx_t rd_ptr, next_rd_ptr; // Next slot to read
  logic [3:0] div_cnt, next_div_cnt; // Conversion clock divider
  logic [3:0] bit_cnt, next_bit_cnt; // Conversion clock periods
  logic [3:0] eoc_cnt, next_eoc_cnt; // End-of-channel pulse timer
  logic start_d, next_start_d; // Previous start level
  logic rd_d, next_rd_d; // Previous read activity
  logic busy, next_busy;
  logic eoc_n, next_eoc_n;
  result_t bus_o, next_bus_o;
  logic bus_oe, next_bus_oe;

  // Lowest set channel of a mask
  function automatic ch_idx_t first_ch(input ch_mask_t m);
    ch_idx_t r;
    r = '0;
    for (int i = `CH_N - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = ch_idx_t'(i);
      end
    end
    return r;
  endfunction

  // Sample word of a channel
  function automatic result_t sample_of(input ch_idx_t c);
    return sample_in[c*`RES_W +: `RES_W];
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Sequencing, storage and read-out
  always_comb begin
    logic rd_act;
    logic start_fall;
    ch_mask_t left;
    rd_act = !port.cs_n && !port.rd_n;
    // Start edge, from any source
    start_fall = start_d && !port.conversion_start_n; // see RULE6
    left = '0;
    next_state = state;
    next_store = store;
    next_pending = pending;
    next_conv_ch = conv_ch;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_div_cnt = div_cnt;
    next_bit_cnt = bit_cnt;
    next_eoc_cnt = eoc_cnt;
    next_start_d = port.conversion_start_n;
    next_rd_d = rd_act;
    next_busy = busy;
    next_eoc_n = 1'b1;
    if (eoc_cnt != '0) begin
      // Hold the end-of-channel pulse low
      next_eoc_cnt = eoc_cnt - 4'h1;
      next_eoc_n = 1'b0;
    end
    case (state)
      ST_IDLE, ST_DONE: begin
        // Start a new sequence on a falling start edge
        if (start_fall && channel_mask != '0) begin
          next_state = ST_CONV;
          next_pending = channel_mask;
          next_conv_ch = first_ch(channel_mask);
          next_wr_ptr = '0;
          next_rd_ptr = '0;
          next_div_cnt = '0;
          next_bit_cnt = '0;
          next_busy = 1'b1;
        end
      end
      ST_CONV: begin
        // Fixed period count from the conversion clock
        if (div_cnt == 4'(`CONV_DIV - 1)) begin // see RULE8
          next_div_cnt = '0;
          if (bit_cnt == 4'(`CONV_BITS - 1)) begin
            next_bit_cnt = '0;
            next_store[wr_ptr] = sample_of(conv_ch);
            next_wr_ptr = wr_ptr + `ONE_CH;
            // One pulse per finished channel
            next_eoc_cnt = `EOC_LEN; // see RULE3
            left = pending & ~(ch_mask_t'(1) << conv_ch);
            next_pending = left;
            next_conv_ch = first_ch(left);
            if (left == '0) begin
              // Whole selection finished
              next_busy = 1'b0; // see RULE1
              next_state = ST_DONE;
            end
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end else begin
          next_div_cnt = div_cnt + 4'h1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Advance read pointer at the end of each read
    if (rd_d && !rd_act) begin
      next_rd_ptr = rd_ptr + `ONE_CH; // see RULE2
    end
    // Drive only during an active read
    next_bus_oe = rd_act; // see RULE4
    next_bus_o = rd_act ? store[rd_ptr] : `ZERO_RES; // see RULE11
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Register all state; read data appears the cycle after the strobe, not the same cycle (see RULE5)
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      for (int i = 0; i < `CH_N; i++) begin
        store[i] <= `ZERO_RES;
      end
      pending <= '0;
      conv_ch <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      div_cnt <= '0;
      bit_cnt <= '0;
      eoc_cnt <= '0;
      start_d <= 1'b1;
      rd_d <= 1'b0;
      busy <= 1'b0;
      eoc_n <= 1'b1;
      bus_o <= `ZERO_RES;
      bus_oe <= 1'b0;
    end else begin
      state <= next_state;
      store <= next_store;
      pending <= next_pending;
      conv_ch <= next_conv_ch;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      div_cnt <= next_div_cnt;
      bit_cnt <= next_bit_cnt;
      eoc_cnt <= next_eoc_cnt;
      start_d <= next_start_d;
      rd_d <= next_rd_d;
      busy <= next_busy;
      eoc_n <= next_eoc_n;
      bus_o <= next_bus_o;
      bus_oe <= next_bus_oe;
    end
  end

  // ************************************************************
  // Pins
  // ************************************************************
  // Pin set of the port (see RULE10)
  assign port.busy = busy;
  assign port.eoc_n = eoc_n;
  assign port.result_bus_o = bus_o;
  assign port.result_bus_oe = bus_oe;

endmodule

/* File: hw/quad_port_defs.svh */
/*
 * Constants for the four-channel converter parallel read port.
 * Assumes inclusion by bare name from the package and both ends.
 */
`ifndef QUAD_PORT_DEFS_SVH
`define QUAD_PORT_DEFS_SVH

// Result width and channel count
`define RES_W 14
`define CH_N 4
`define CH_W 2
// Conversion clock rate in kHz and system clock in kHz
`define CONV_CLK_KHZ 5000
`define SYS_CLK_KHZ 40000
// System cycles per conversion clock period
`define CONV_DIV (`SYS_CLK_KHZ / `CONV_CLK_KHZ)
// Conversion clock periods per channel conversion
`define CONV_BITS 12
// End-of-channel pulse length in system cycles
`define EOC_LEN 4'h2
// Host software wait in system cycles when polling
`define HOST_WAIT 12'h200
// Host read strobe length in system cycles
`define RD_LEN 4'h2
// Constant values
`define ZERO_RES 14'h0000
`define ALL_CH 4'hF
`define ONE_CH 2'h1

`endif

/* File: hw/quad_port_pkg.sv */
/*
 * Types shared by both ends of the parallel read port.
 * Assumes quad_port_defs.svh is on the include path.
 */
`include "quad_port_defs.svh"

package quad_port_pkg;
  // Result word
  typedef logic [`RES_W-1:0] result_t;
  // Channel select mask
  typedef logic [`CH_N-1:0] ch_mask_t;
  // Channel index
  typedef logic [`CH_W-1:0] ch_idx_t;
endpackage

/* File: hw/quad_port_if.sv */
/*
 * Pins between the converter and its host.
 * Assumes one shared clock; resolves the result bus from enables.
 */
`timescale 1ns/1ps
`include "quad_port_defs.svh"

interface quad_port_if;
  import quad_port_pkg::*;
  // Start, strobes and status
  logic conversion_start_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic eoc_n;
  logic busy;
  // Result bus, drive value and enable plus resolved level
  result_t result_bus_o;
  logic result_bus_oe;
  result_t result_bus;
  // Resolved level; undriven bus reads as zero
  assign result_bus = result_bus_oe ? result_bus_o : `ZERO_RES;

  // Converter end
  modport device (
    input conversion_start_n, cs_n, rd_n, wr_n,
    output eoc_n, busy, result_bus_o, result_bus_oe
  );
  // Host end
  modport host (
    output conversion_start_n, cs_n, rd_n, wr_n,
    input eoc_n, busy, result_bus
  );
endinterface

/* File: hw/quad_port_host.sv */
/*
 * Host end: starts a sequence, waits on busy or a fixed delay,
 * then reads the selected results back to back.
 * Assumes the device end on the same clk_sys.
 */
`timescale 1ns/1ps
`include "quad_port_defs.svh"

module quad_port_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // User requests
  input wire logic start_req,
  input wire logic use_busy,
  input wire logic [2:0] read_count,
  // User results
  output quad_port_pkg::result_t rd_data,
  output logic rd_valid,
  output logic seq_done,
  // Device pins
  quad_port_if.host port
);
  import quad_port_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_WAIT = 3'b010,
    H_READ = 3'b011,
    H_GAP = 3'b100
  } host_state_t;

  host_state_t state, next_state;
  logic [11:0] wait_cnt, next_wait_cnt; // Software delay
  logic [3:0] rd_cnt, next_rd_cnt; // Strobe timer
  logic [2:0] left, next_left; // Reads remaining
  logic busy_seen, next_busy_seen; // Busy rose this sequence
  logic start_n, next_start_n;
  logic cs_n, next_cs_n;
  logic rd_n, next_rd_n;
  result_t data, next_data;
  logic valid, next_valid;
  logic done, next_done;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Start, completion wait and back-to-back reads
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_rd_cnt = rd_cnt;
    next_left = left;
    next_busy_seen = busy_seen | port.busy;
    next_start_n = 1'b1;
    next_cs_n = cs_n;
    next_rd_n = rd_n;
    next_data = data;
    next_valid = 1'b0;
    next_done = 1'b0;
    case (state)
      H_IDLE: begin
        if (start_req && read_count != 3'h0) begin
          // Host-driven start pulse (see RULE6)
          next_start_n = 1'b0;
          next_left = read_count;
          next_busy_seen = 1'b0;
          next_wait_cnt = `HOST_WAIT;
          next_state = H_START;
        end
      end
      H_START: begin
        next_state = H_WAIT;
      end
      H_WAIT: begin
        if (wait_cnt != 12'h0) begin
          next_wait_cnt = wait_cnt - 12'h1;
        end
        // Busy interrupt, or software delay when polling
        if ((use_busy && busy_seen && !port.busy) ||
            (!use_busy && wait_cnt == 12'h0)) begin // see RULE7
          next_cs_n = 1'b0;
          next_rd_n = 1'b0;
          next_rd_cnt = `RD_LEN;
          next_state = H_READ;
        end
      end
      H_READ: begin
        next_rd_cnt = rd_cnt - 4'h1;
        if (rd_cnt == 4'h1) begin
          // Capture and end the read strobe
          next_data = port.result_bus;
          next_valid = 1'b1;
          next_cs_n = 1'b1;
          next_rd_n = 1'b1;
          next_left = left - 3'h1;
          next_state = H_GAP;
        end
      end
      H_GAP: begin
        // Next read follows directly (see RULE2)
        if (left == 3'h0) begin
          next_done = 1'b1;
          next_state = H_IDLE;
        end else begin
          next_cs_n = 1'b0;
          next_rd_n = 1'b0;
          next_rd_cnt = `RD_LEN;
          next_state = H_READ;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Register all host state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= H_IDLE;
      wait_cnt <= '0;
      rd_cnt <= '0;
      left <= '0;
      busy_seen <= 1'b0;
      start_n <= 1'b1;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      data <= `ZERO_RES;
      valid <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      rd_cnt <= next_rd_cnt;
      left <= next_left;
      busy_seen <= next_busy_seen;
      start_n <= next_start_n;
      cs_n <= next_cs_n;
      rd_n <= next_rd_n;
      data <= next_data;
      valid <= next_valid;
      done <= next_done;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Pins and user outputs from flip-flops, except wr_n tied high
  assign port.conversion_start_n = start_n;
  assign port.cs_n = cs_n;
  assign port.rd_n = rd_n;
  assign port.wr_n = 1'b1;
  assign rd_data = data;
  assign rd_valid = valid;
  assign seq_done = done;

endmodule

/* File: verif/quad_port_sva.sv */
/*
 * Checker on the pins between converter and host.
 * Assumes one clk_sys domain and a synchronous active-low rst_n.
 */
`timescale 1ns/1ps

module quad_port_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Strobes and status
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic eoc_n,
  input wire logic busy,
  // Device bus drive
  input wire quad_port_pkg::result_t result_bus_o,
  input wire logic result_bus_oe
);
  import quad_port_pkg::*;
  // ****************************************
  // Pin relations
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // One more low cycle after the fall, then back high
  sequence eoc_pulse;
    !eoc_n ##1 eoc_n;
  endsequence
  // Active read strobe pair
  sequence read_strobe;
    !cs_n && !rd_n;
  endsequence

  a_oe_needs_read: assert property (
    result_bus_oe |-> $past(!cs_n && !rd_n))
    else $error("bus driven without a read strobe");
  a_read_no_wait: assert property (read_strobe |=> result_bus_oe)
    else $error("read not answered next cycle");
  a_bus_release: assert property (
    (cs_n || rd_n) |=> !result_bus_oe)
    else $error("bus not released after strobe");
  a_data_steady: assert property (
    result_bus_oe && $past(result_bus_oe) |-> $stable(result_bus_o))
    else $error("read data changed inside a read");
  a_start_busy: assert property (
    $fell(conversion_start_n) && !busy |=> busy)
    else $error("busy not raised after start");
  a_eoc_width: assert property ($fell(eoc_n) |=> eoc_pulse)
    else $error("end of channel pulse length wrong");
  // Busy drops on the store edge, the pulse starts one cycle later
  a_busy_end_eoc: assert property (
    $fell(busy) |-> ##1 $fell(eoc_n))
    else $error("busy fell away from last channel");
  // First pulse seen 97 cycles after busy is first seen high
  a_first_chan: assert property (
    $rose(busy) |-> ##97 $fell(eoc_n))
    else $error("first channel time not 97 cycles");
  a_chan_spacing: assert property (
    $fell(eoc_n) && busy |-> ##96 $fell(eoc_n))
    else $error("channel spacing not 96 cycles");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:400] !busy)
    else $error("sequence did not finish in time");
endmodule

/* File: verif/tb.sv */
/*
 * Bench joining converter and host through the shared interface.
 * Assumes 40 MHz clk_sys; results checked in ascending channel order.
 */
`timescale 1ns/1ps
`include "quad_port_defs.svh"

module tb;
  import quad_port_pkg::*;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic use_busy = 1'b0;
  logic [2:0] read_count = 3'h0;
  ch_mask_t channel_mask = 4'h0;
  logic [`CH_N*`RES_W-1:0] sample_in = '0;
  result_t rd_data;
  logic rd_valid;
  logic seq_done;
  int err_total = 0;
  int cmp_count = 0;
  int eoc_seen = 0;
  result_t got_q[$];

  // Shared pins
  quad_port_if port_if ();
  quad_adc_parallel_read_port quad_adc_parallel_read_port_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .channel_mask(channel_mask),
    .sample_in(sample_in), .port(port_if.device));
  quad_port_host quad_port_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .start_req(start_req),
    .use_busy(use_busy), .read_count(read_count), .rd_data(rd_data),
    .rd_valid(rd_valid), .seq_done(seq_done), .port(port_if.host));
  quad_port_sva quad_port_sva_inst (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .conversion_start_n(port_if.conversion_start_n),
    .cs_n(port_if.cs_n), .rd_n(port_if.rd_n), .eoc_n(port_if.eoc_n),
    .busy(port_if.busy), .result_bus_o(port_if.result_bus_o),
    .result_bus_oe(port_if.result_bus_oe));

  // Clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  // Collect host words and count channel pulses
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      got_q.push_back(rd_data);
    end
    if (rst_n && $fell(port_if.eoc_n)) begin
      eoc_seen++;
    end
  end

  // Compare one value
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One full sequence: start, wait, read, compare
  task automatic run_seq(ch_mask_t mask, logic wait_busy, result_t base);
    result_t exp_q[$];
    int k;
    int n;
    n = 0;
    for (k = 0; k < `CH_N; k++) begin
      sample_in[k*`RES_W +: `RES_W] <= base ^ result_t'(k * 16'h0111);
      if (mask[k]) begin
        exp_q.push_back(base ^ result_t'(k * 16'h0111));
        n++;
      end
    end
    got_q.delete();
    eoc_seen = 0;
    channel_mask <= mask;
    use_busy <= wait_busy;
    read_count <= 3'(n);
    @(posedge clk_sys);
    start_req <= 1'b1;
    @(posedge clk_sys);
    start_req <= 1'b0;
    for (k = 0; k < 2000; k++) begin
      @(negedge clk_sys);
      if (seq_done === 1'b1) begin
        break;
      end
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("seq_done", 16'h0001, 16'(k < 2000));
    check("busy", 16'h0000, 16'(port_if.busy));
    check("eoc count", 16'(n), 16'(eoc_seen));
    check("word count", 16'(n), 16'(got_q.size()));
    for (k = 0; k < n && k < got_q.size(); k++) begin
      check("rd_data", 16'(exp_q[k]), 16'(got_q[k]));
    end
    // Leave on a rising edge so the next call drives there
    @(posedge clk_sys);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    run_seq(4'hF, 1'b1, 14'h2A5C);
    run_seq(4'hA, 1'b0, 14'h13C7);
    run_seq(4'h1, 1'b1, 14'h3FFF);
    run_seq(4'h6, 1'b1, 14'h0000);
    test_done();
  end

  // Watchdog on the whole run
  initial begin
    repeat (8000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
endmodule
